// ### piu_top.sv
/*
 * piu_top: prioritized interrupt unit of a 16-bit core.
 * assumes: source events and instruction strobes are core-clock logic,
 * one cycle wide; the sequencer performs the push and the vector fetch.
 */
// Operation
// - service only while global enable set
// - disabled requests stay latched, served later
// - events set request latch at 09H
// - request latch byte readable and writable
// - enable mask at 08H, one enables
// - masked sources still latch their requests
// - mask is low byte of status word
// - fixed priority, level 7 highest
// - vector word 2000H plus two per level
// - bit n belongs to priority n
// - call pushes pc, loads vector word
// - no service right after interrupt call
// - status push saves then clears word
// - no service right after status push
// - status pop restores, blocks next boundary
// - service only at instruction boundaries
`timescale 1ns/1ps
`default_nettype none
module piu_top
	import piu_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic [PIU_SRC_N-1:0] i_src_event,
	input wire piu_instr_t i_instr,
	input wire piu_reg_wr_t i_reg_wr,
	input wire logic [7:0] i_reg_raddr,
	input wire logic i_status_wr,
	input wire logic [15:0] i_status_wdata,
	input wire logic i_call_done,
	output logic [7:0] o_reg_rdata,
	output logic [15:0] o_processor_status_word,
	output piu_call_t o_call,
	output logic [15:0] o_call_vector
);
	logic [7:0] enable_bits_ff;
	logic [7:0] request_latch_ff;
	logic [7:0] status_hi_ff;
	logic block_ff;
	logic call_busy_ff;
	logic [7:0] nxt_request_latch;
	logic [7:0] eligible;
	logic arb_any;
	logic [2:0] arb_src;
	logic take;
	logic wr_enable;
	logic wr_latch;
	logic [15:0] status_word;

	assign wr_enable = i_reg_wr.wr && (i_reg_wr.addr == PIU_ADDR_ENABLE_BITS);
	assign wr_latch = i_reg_wr.wr && (i_reg_wr.addr == PIU_ADDR_REQUEST_LATCH);
	assign status_word = {status_hi_ff, enable_bits_ff};

	// eligibility: pending, mask and global enable all set
	assign eligible = request_latch_ff & enable_bits_ff
		& {PIU_SRC_N{status_hi_ff[PIU_GIE_BIT-8]}};

	piu_prio_arb u_arb (
		.i_req(eligible),
		.o_any(arb_any),
		.o_src(arb_src)
	);

	// taken only at a boundary, not while held off or a call is in flight
	assign take = arb_any && i_instr.boundary && !block_ff
		&& !call_busy_ff && !i_instr.status_push_instr
		&& !i_instr.status_pop_instr;

	// request latch: software write first, then call clear, then events;
	// events win over a software clear so no request is lost
	always_comb begin
		nxt_request_latch = request_latch_ff;
		if (wr_latch) begin
			nxt_request_latch = i_reg_wr.wdata;
		end
		if (take) begin
			nxt_request_latch[arb_src] = 1'b0;
		end
		nxt_request_latch = nxt_request_latch | i_src_event;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			request_latch_ff <= PIU_RST_REQUEST_LATCH;
		end else begin
			request_latch_ff <= nxt_request_latch;
		end
	end

	// enable mask, shared with the status word low byte
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			enable_bits_ff <= PIU_RST_ENABLE_BITS;
		end else if (i_instr.status_push_instr) begin
			enable_bits_ff <= PIU_RST_ENABLE_BITS;
		end else if (i_instr.status_pop_instr) begin
			enable_bits_ff <= i_status_wdata[7:0];
		end else if (i_status_wr) begin
			enable_bits_ff <= i_status_wdata[7:0];
		end else if (wr_enable) begin
			enable_bits_ff <= i_reg_wr.wdata;
		end
	end

	// upper status byte: arithmetic flags and global enable
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			status_hi_ff <= PIU_RST_STATUS_HI[15:8];
		end else if (i_instr.status_push_instr) begin
			status_hi_ff <= PIU_RST_STATUS_HI[15:8];
		end else if (i_instr.status_pop_instr || i_status_wr) begin
			status_hi_ff <= i_status_wdata[15:8];
		end else if (i_instr.enable_servicing_instr) begin
			status_hi_ff[PIU_GIE_BIT-8] <= 1'b1;
		end else if (i_instr.disable_servicing_instr) begin
			status_hi_ff[PIU_GIE_BIT-8] <= 1'b0;
		end
	end

	// hold-off: the boundary after a call, push or pop never services;
	// cleared at the next boundary, so exactly one instruction runs
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			block_ff <= 1'b0;
		end else if (take || i_instr.status_push_instr
			|| i_instr.status_pop_instr) begin
			block_ff <= 1'b1;
		end else if (i_instr.boundary && !call_busy_ff) begin
			// a boundary inside a call must not spend the hold-off
			block_ff <= 1'b0;
		end
	end

	// call stays requested until the sequencer finishes push and load
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			call_busy_ff <= 1'b0;
			o_call <= '0;
			o_call_vector <= PIU_VECTOR_BASE;
		end else if (take) begin
			call_busy_ff <= 1'b1;
			o_call.take <= 1'b1;
			o_call.src <= arb_src;
			o_call.vector_addr <= PIU_VECTOR_BASE
				+ 16'(arb_src) * PIU_VECTOR_STEP;
			o_call_vector <= PIU_VECTOR_BASE + 16'(arb_src) * PIU_VECTOR_STEP;
		end else if (i_call_done) begin
			call_busy_ff <= 1'b0;
			o_call.take <= 1'b0;
		end
	end

	// register reads; unmapped addresses read zero, no side effects
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_raddr == PIU_ADDR_ENABLE_BITS) begin
			o_reg_rdata <= enable_bits_ff;
		end else if (i_reg_raddr == PIU_ADDR_REQUEST_LATCH) begin
			o_reg_rdata <= request_latch_ff;
		end else begin
			o_reg_rdata <= 8'h00;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_processor_status_word <= PIU_RST_STATUS_HI;
		end else begin
			o_processor_status_word <= status_word;
		end
	end
endmodule : piu_top
`default_nettype wire

// ### piu_pkg.sv
/*
 * piu_pkg: constants and carrier types of the prioritized interrupt unit.
 * assumes: included before every design file of the unit; no clock here.
 */
package piu_pkg;
	localparam int PIU_SRC_N = 8;
	localparam logic [7:0] PIU_ADDR_ENABLE_BITS = 8'h08;
	localparam logic [7:0] PIU_ADDR_REQUEST_LATCH = 8'h09;
	localparam logic [7:0] PIU_RST_ENABLE_BITS = 8'h00;
	localparam logic [7:0] PIU_RST_REQUEST_LATCH = 8'h00;
	localparam logic [15:0] PIU_RST_STATUS_HI = 16'h0000;
	localparam logic [15:0] PIU_VECTOR_BASE = 16'h2000;
	localparam logic [15:0] PIU_VECTOR_STEP = 16'h0002;
	localparam int PIU_GIE_BIT = 9;
	localparam logic [2:0] PIU_SRC_TIMER_OVF = 3'h0;
	localparam logic [2:0] PIU_SRC_CONVERTER = 3'h1;
	localparam logic [2:0] PIU_SRC_CAPTURE_DATA = 3'h2;
	localparam logic [2:0] PIU_SRC_TIMED_OUTPUT = 3'h3;
	localparam logic [2:0] PIU_SRC_CAPTURE_PIN0 = 3'h4;
	localparam logic [2:0] PIU_SRC_SOFT_TIMER = 3'h5;
	localparam logic [2:0] PIU_SRC_SERIAL = 3'h6;
	localparam logic [2:0] PIU_SRC_EXTERNAL = 3'h7;

	// one-cycle instruction-retire strobes from the sequencer
	typedef struct packed {
		logic boundary;
		logic enable_servicing_instr;
		logic disable_servicing_instr;
		logic status_push_instr;
		logic status_pop_instr;
	} piu_instr_t;

	// register-file byte access from the core
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} piu_reg_wr_t;

	// interrupt call request towards the sequencer
	typedef struct packed {
		logic take;
		logic [2:0] src;
		logic [15:0] vector_addr;
	} piu_call_t;
endpackage : piu_pkg

// ### piu_prio_arb.sv
/*
 * piu_prio_arb: fixed-priority pick among the eligible sources.
 * assumes: request vector already gated by mask and global enable.
 */
`timescale 1ns/1ps
`default_nettype none
module piu_prio_arb
	import piu_pkg::*;
(
	input wire logic [PIU_SRC_N-1:0] i_req,
	output logic o_any,
	output logic [2:0] o_src
);
	// highest bit wins; scan upward so the last hit is the highest level
	always_comb begin
		o_any = 1'b0;
		o_src = 3'h0;
		for (int i = 0; i < PIU_SRC_N; i++) begin
			if (i_req[i]) begin
				o_any = 1'b1;
				o_src = 3'(i);
			end
		end
	end
endmodule : piu_prio_arb
`default_nettype wire

// ### piu_top_sva.sv
/* piu_top_sva: port checks of the interrupt unit.
   assumes: bound to piu_top, single clock. */
`timescale 1ns/1ps
`default_nettype none
module piu_top_sva
	import piu_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire piu_instr_t i_instr,
	input wire logic i_call_done,
	input wire logic [15:0] o_processor_status_word,
	input wire piu_call_t o_call,
	input wire logic [15:0] o_call_vector
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	logic hold_ff;
	// hold-off armed by call end, push or pop, spent at a boundary
	always_ff @(posedge i_ref_clk) begin
		hold_ff <= i_rst_b && (i_instr.status_push_instr
			|| i_instr.status_pop_instr || (o_call.take && i_call_done)
			|| (hold_ff && !i_instr.boundary));
	end
	sequence s_call_end;
		o_call.take && i_call_done;
	endsequence
	a_vec_map: assert property (o_call.take |->
		o_call.vector_addr == 16'h2000 + {12'h000, o_call.src, 1'h0})
		else $error("vector");
	a_vec_copy: assert property (o_call.take |->
		o_call_vector == o_call.vector_addr) else $error("vector copy");
	a_take_edge: assert property ($rose(o_call.take) |->
		$past(i_instr.boundary)) else $error("call off boundary");
	a_take_hold: assert property (o_call.take && !i_call_done |=>
		o_call.take && $stable(o_call.src)) else $error("call dropped");
	a_take_drop: assert property (s_call_end |=> !o_call.take)
		else $error("call kept");
	a_hold_off: assert property (
		hold_ff && i_instr.boundary |=> !$rose(o_call.take))
		else $error("call in hold-off");
	a_push_same: assert property (
		i_instr.status_push_instr || i_instr.status_pop_instr
		|=> !$rose(o_call.take)) else $error("call at push or pop");
	a_push_clear: assert property (i_instr.status_push_instr |->
		##[1:2] o_processor_status_word == 16'h0000) else $error("push");
endmodule : piu_top_sva
`default_nettype wire

// ### piu_seq_model.sv
/* piu_seq_model: sequencer answering interrupt calls.
   assumes: done pulse follows take after DLY+1 cycles. */
`timescale 1ns/1ps
`default_nettype none
module piu_seq_model
	import piu_pkg::*;
#(parameter int DLY = 2) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire piu_call_t i_call,
	output logic o_call_done
);
	int cnt;
	// pc push and vector fetch; a larger DLY models a slow stack
	always_ff @(posedge i_ref_clk) begin
		cnt <= (i_call.take && !o_call_done) ? cnt + 1 : 0;
		o_call_done <= i_rst_b && i_call.take && !o_call_done && cnt == DLY;
	end
endmodule : piu_seq_model
`default_nettype wire

// ### test_prioritized_interrupt_unit.sv
/* test_prioritized_interrupt_unit: port tests of piu_top.
   assumes: piu_seq_model answers calls; checker bound at the foot. */
`timescale 1ns/1ps
`default_nettype none
module test_prioritized_interrupt_unit;
	import piu_pkg::*;
	logic clk = 1'h0, rst_b = 1'h0, done, swr = 1'h0;
	logic [7:0] ev = 8'h00, ra = 8'h00, rdat;
	logic [15:0] swd = 16'h0280, processor_status_word, vec;
	piu_instr_t ins = '0;
	piu_reg_wr_t rw = '0;
	piu_call_t call;
	int error_cnt = 0, num_checks = 0, cyc = 0;
	piu_top piu_top_inst (.i_ref_clk(clk), .i_rst_b(rst_b), .i_src_event(ev),
		.i_instr(ins), .i_reg_wr(rw), .i_reg_raddr(ra), .i_status_wr(swr),
		.i_status_wdata(swd), .i_call_done(done), .o_reg_rdata(rdat),
		.o_processor_status_word(processor_status_word), .o_call(call), .o_call_vector(vec));
	piu_seq_model #(.DLY(2)) piu_seq_model_inst (.i_ref_clk(clk),
		.i_rst_b(rst_b), .i_call(call), .o_call_done(done));
	// 10 MHz clock and a hang guard far above the run length
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic chk(input logic [15:0] g, e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk);
		rw <= '{1'h1, a, d};
		@(posedge clk);
		rw <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, e);
		@(posedge clk);
		ra <= a;
		@(posedge clk);
		@(negedge clk);
		chk({8'h00, rdat}, {8'h00, e});
	endtask : rd
	// one retire strobe, then a call to source s expected or none
	task automatic step(input piu_instr_t v, input logic t, input logic [2:0] s);
		@(posedge clk);
		ins <= v;
		@(posedge clk);
		ins <= '0;
		repeat (2) @(negedge clk);
		chk({15'h0000, call.take}, {15'h0000, t});
		if (t)
			chk(vec, 16'h2000 + 16'(s) * 16'h0002);
		for (int n = 0; n < 8 && call.take === 1'h1; n++)
			@(negedge clk);
	endtask : step
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up
	// registers, priority walk, then status push and pop
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'h1;
		rd(8'h0a, 8'h00);
		rd(8'h08, 8'h00);
		chk(vec, 16'h2000);
		@(posedge clk);
		ev <= 8'hff;
		@(posedge clk);
		ev <= 8'h00;
		rd(8'h09, 8'hff);
		wr(8'h09, 8'h0a);
		rd(8'h09, 8'h0a);
		wr(8'h08, 8'hff);
		rd(8'h08, 8'hff);
		chk(processor_status_word, 16'h00ff);
		step(5'h10, 1'h0, 3'h0);
		wr(8'h09, 8'hff);
		step(5'h08, 1'h0, 3'h0);
		chk(processor_status_word, 16'h02ff);
		$display("test 1 done");
		for (int i = 7; i >= 0; i--) begin
			step(5'h10, 1'h1, 3'(i));
			step(5'h10, 1'h0, 3'h0);
		end
		rd(8'h09, 8'h00);
		$display("test 2 done");
		wr(8'h08, 8'h01);
		wr(8'h09, 8'h80);
		step(5'h10, 1'h0, 3'h0);
		step(5'h12, 1'h0, 3'h0);
		chk(processor_status_word, 16'h0000);
		@(posedge clk);
		swr <= 1'h1;
		@(posedge clk);
		swr <= 1'h0;
		step(5'h00, 1'h0, 3'h0);
		chk(processor_status_word, 16'h0280);
		step(5'h10, 1'h0, 3'h0);
		step(5'h11, 1'h0, 3'h0);
		chk(processor_status_word, 16'h0280);
		step(5'h10, 1'h0, 3'h0);
		step(5'h10, 1'h1, 3'h7);
		step(5'h14, 1'h0, 3'h0);
		chk(processor_status_word, 16'h0080);
		$display("test 3 done");
		wrap_up();
	end
endmodule : test_prioritized_interrupt_unit
bind piu_top piu_top_sva piu_top_sva_inst (.i_ref_clk, .i_rst_b, .i_instr,
	.i_call_done, .o_processor_status_word, .o_call, .o_call_vector);
`default_nettype wire
